/* core/bmc_device.sv */
// device end: calibration, protection and FET control of the monitor
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
module bmc_device
  import bmc_pkg::*;
#(
  parameter logic [15:0] TRIM_OFS = 16'h0000,
  parameter logic [COEF_W-1:0] OV_TRIM = 8'hA0,
  parameter logic [COEF_W-1:0] UV_TRIM = 8'h4B,
  parameter int EVAL_CYC = 250,
  parameter int WDOG_CYC = 2500,
  parameter int PCHG_CYC = 2500
)
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  bmc_link_if.dev link,
  input wire logic [15:0] cell_raw_i,
  input wire logic [15:0] top_raw_i,
  input wire logic [15:0] div_raw_i,
  input wire logic signed [31:0] cc_raw_i,
  input wire logic [NTS-1:0][15:0] temp_raw_i,
  input wire logic pchg_active_i,
  input wire logic fail_trigger_i,
  input wire logic fuse_i,
  output logic fuse_o,
  output logic fuse_oe_o,
  output logic charge_fet_o,
  output logic discharge_fet_o,
  output logic permanent_fail_o
);
  localparam int TW = $clog2(EVAL_CYC + 1);
  localparam int WW = $clog2(WDOG_CYC + 1);
  localparam int PW = $clog2(PCHG_CYC + 1);

  logic mode_r;
  logic signed [15:0] vcofs_r;
  logic signed [15:0] vdofs_r;
  logic [15:0] cgain_r;
  logic [15:0] dgain_r;
  logic [15:0] ccsmp_r;
  logic signed [31:0] ccofs_r;
  logic [31:0] ccgain_r;
  logic [31:0] cap_r;
  logic [COEF_W-1:0] ovovr_r;
  logic [COEF_W-1:0] uvovr_r;
  logic [NPR-1:0] pen_r;
  logic [NPR-1:0] pauto_r;
  logic [NPR-1:0] fault_r;
  logic [NPR-1:0] fw_hit_r;
  logic [1:0] recov_r;
  logic [1:0] failresp_r;
  logic [1:0] hostfet_r;
  logic signed [15:0] tofs_r [NTS];
  logic signed [31:0] thr_r [NTH];
  logic fail_r;
  logic fuse_seen_r;
  logic cal_uv_r;
  logic cal_busy_r;
  logic [1:0] cblk_s_r;
  logic [1:0] dblk_s_r;
  logic [1:0] fuse_s_r;
  logic [TW-1:0] tick_r;
  logic [WW-1:0] wd_r;
  logic [PW-1:0] pch_r;
  logic rsp_vld_r;
  logic rsp_err_r;
  logic [DW-1:0] rsp_dat_r;
  logic alert_r;

  ////////////////////////////////////////////////////////////////////////
  // calibrated measurements
  wire logic signed [31:0] cell_mv = cal_volt(cell_raw_i, TRIM_OFS,
    cgain_r, vcofs_r);
  wire logic signed [31:0] top_mv = cal_volt(top_raw_i, TRIM_OFS,
    cgain_r, vcofs_r);
  wire logic signed [31:0] div_v = cal_volt(div_raw_i, TRIM_OFS,
    dgain_r, vdofs_r);
  // a zero sample count would divide by zero, so it counts as one
  wire logic [15:0] smp_w = (ccsmp_r == 16'h0000) ? SMP_RST : ccsmp_r;
  wire logic signed [31:0] ofs_cnt_w = ccofs_r / $signed({16'h0000, smp_w});
  wire logic signed [31:0] cur_w = fmul_if(cc_raw_i - ofs_cnt_w,
    ccgain_r);
  logic signed [15:0] tc_w [NTS];
  logic ot_any;
  logic ut_any;

  always_comb
  begin
    ot_any = 1'b0;
    ut_any = 1'b0;
    for (int i = 0; i < NTS; i++)
    begin
      tc_w[i] = $signed(temp_raw_i[i]) + tofs_r[i];
      if (tc_w[i] > thr_r[T_OT])
        ot_any = 1'b1;
      if (tc_w[i] < thr_r[T_UT])
        ut_any = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // protection evaluation
  wire logic signed [31:0] ov_mv = coef_mv((ovovr_r != 8'h00) ?
    ovovr_r : OV_TRIM);
  wire logic signed [31:0] uv_mv = coef_mv((uvovr_r != 8'h00) ?
    uvovr_r : UV_TRIM);
  wire logic tick_w = tick_r == TW'(EVAL_CYC - 1);
  logic [NPR-1:0] now_c;

  always_comb
  begin
    now_c = {NPR{1'b0}};
    now_c[P_UV] = cell_mv < uv_mv;
    now_c[P_OV] = cell_mv > ov_mv;
    now_c[P_OCC] = cur_w > thr_r[T_OCC];
    now_c[P_OCD1] = -cur_w > thr_r[T_OCD1];
    now_c[P_OCD2] = -cur_w > thr_r[T_OCD2];
    now_c[P_OCD3] = -cur_w > thr_r[T_OCD3];
    now_c[P_SCD] = -cur_w > thr_r[T_SCD];
    now_c[P_OT] = ot_any;
    now_c[P_UT] = ut_any;
    now_c[P_WDG] = wd_r == WW'(WDOG_CYC);
    now_c[P_PCH] = pch_r == PW'(PCHG_CYC);
  end

  // comparator bits act at once, firmware bits only at each evaluation
  wire logic [NPR-1:0] hit_w = ((now_c & ~FW_MASK) | (fw_hit_r & FW_MASK))
    & pen_r;

  ////////////////////////////////////////////////////////////////////////
  // link decode
  wire logic [AW-1:0] a = link.req_addr;
  wire logic [DW-1:0] d = link.req_data;
  wire logic wr_w = link.req_vld && link.req_kind == KIND_WR;
  wire logic rd_w = link.req_vld && link.req_kind == KIND_RD;
  wire logic sub_w = link.req_vld && link.req_kind == KIND_SUB;
  wire logic tofs_hit = a >= A_TOFS && a < A_TOFS + NTS;
  wire logic thr_hit = a >= A_THR && a < A_THR + NTH;
  wire logic temp_hit = a >= A_TEMP && a < A_TEMP + NTS;
  wire logic [3:0] tofs_ix = 4'(a - A_TOFS);
  wire logic [2:0] thr_ix = 3'(a - A_THR);
  wire logic [3:0] temp_ix = 4'(a - A_TEMP);
  wire logic cal_ok_w = sub_w && mode_r && !cal_busy_r &&
    (d == SUB_CAL_OV || d == SUB_CAL_UV);
  wire logic [NPR-1:0] clr_w = (wr_w && a == A_FAULT) ?
    d[NPR-1:0] : {NPR{1'b0}};
  wire logic [COEF_W-1:0] coef_w;
  wire logic cal_done_w;
  logic [DW-1:0] rdat_c;
  logic rok_c;
  logic wok_c;

  always_comb
  begin
    rdat_c = 32'h00000000;
    rok_c = 1'b1;
    wok_c = 1'b1;
    if (a == A_MODE) rdat_c = {31'h00000000, mode_r};
    else if (a == A_VCOFS) rdat_c = 32'(vcofs_r);
    else if (a == A_VDOFS) rdat_c = 32'(vdofs_r);
    else if (a == A_CGAIN) rdat_c = {16'h0000, cgain_r};
    else if (a == A_DGAIN) rdat_c = {16'h0000, dgain_r};
    else if (a == A_CCOFS) rdat_c = ccofs_r;
    else if (a == A_CCSMP) rdat_c = {16'h0000, ccsmp_r};
    else if (a == A_CCGAIN) rdat_c = ccgain_r;
    else if (a == A_OVOVR) rdat_c = 32'(ovovr_r);
    else if (a == A_UVOVR) rdat_c = 32'(uvovr_r);
    else if (a == A_PEN) rdat_c = 32'(pen_r);
    else if (a == A_PAUTO) rdat_c = 32'(pauto_r);
    else if (a == A_RECOV) rdat_c = 32'(recov_r);
    else if (a == A_FAILRESP) rdat_c = 32'(failresp_r);
    else if (a == A_FETCTL) rdat_c = 32'(hostfet_r);
    else if (a == A_FAULT) rdat_c = 32'(fault_r);
    else if (tofs_hit) rdat_c = 32'(tofs_r[tofs_ix]);
    else if (thr_hit) rdat_c = thr_r[thr_ix];
    else
    begin
      wok_c = 1'b0;
      if (a == A_CAPGAIN) rdat_c = cap_r;
      else if (a == A_CELLV) rdat_c = cell_mv;
      else if (a == A_DIVV) rdat_c = div_v;
      else if (a == A_CUR) rdat_c = cur_w;
      else if (a == A_STAT)
        rdat_c = {26'h0000000, cal_busy_r, fuse_seen_r, fail_r,
          discharge_fet_o, charge_fet_o, mode_r};
      else if (temp_hit) rdat_c = 32'(tc_w[temp_ix]);
      else rok_c = 1'b0;
    end
  end

  bmc_cal_search bmc_cal_search_inst (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .start_i(cal_ok_w),
    .level_mv_i(top_mv),
    .coef_o(coef_w),
    .done_o(cal_done_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // fault, permanent fail and FET gates
  wire logic [NPR-1:0] fault_nxt = (recov_r == REC_AUTO) ? hit_w :
    ((fault_r & ~clr_w) | hit_w);
  wire logic [NPR-1:0] act_w = (recov_r == REC_ALERT) ? {NPR{1'b0}} :
    (fault_r & pauto_r);
  wire logic ext_fuse_w = fuse_s_r[1] && !fuse_oe_o;
  wire logic fail_off_w = fail_r && failresp_r != FAIL_FLAG;
  wire logic chg_nxt = hostfet_r[0] && !cblk_s_r[1] && !fail_off_w &&
    !(|(act_w & CHARGE_MASK));
  wire logic dsg_nxt = hostfet_r[1] && !dblk_s_r[1] && !fail_off_w &&
    !(|(act_w & DISCH_MASK));

  assign link.rsp_vld = rsp_vld_r;
  assign link.rsp_err = rsp_err_r;
  assign link.rsp_data = rsp_dat_r;
  assign link.alert = alert_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cblk_s_r <= 2'h0;
      dblk_s_r <= 2'h0;
      fuse_s_r <= 2'h0;
      tick_r <= '0;
      wd_r <= '0;
      pch_r <= '0;
      fw_hit_r <= {NPR{1'b0}};
      fault_r <= {NPR{1'b0}};
      alert_r <= 1'b0;
      fail_r <= 1'b0;
      fuse_seen_r <= 1'b0;
      fuse_o <= 1'b0;
      fuse_oe_o <= 1'b0;
      charge_fet_o <= 1'b0;
      discharge_fet_o <= 1'b0;
      permanent_fail_o <= 1'b0;
    end
    else
    begin
      cblk_s_r <= {cblk_s_r[0], link.charge_fet_block_pin};
      dblk_s_r <= {dblk_s_r[0], link.discharge_fet_block_pin};
      fuse_s_r <= {fuse_s_r[0], fuse_i};
      tick_r <= tick_w ? '0 : tick_r + 1'b1;
      if (link.req_vld)
        wd_r <= '0;
      else if (wd_r != WW'(WDOG_CYC))
        wd_r <= wd_r + 1'b1;
      if (!pchg_active_i)
        pch_r <= '0;
      else if (pch_r != PW'(PCHG_CYC))
        pch_r <= pch_r + 1'b1;
      if (tick_w)
        fw_hit_r <= now_c & FW_MASK;
      fault_r <= fault_nxt;
      alert_r <= |fault_r;
      fail_r <= fail_r || fail_trigger_i || ext_fuse_w;
      fuse_seen_r <= fuse_seen_r || ext_fuse_w;
      fuse_o <= fail_r && failresp_r == FAIL_FUSE;
      fuse_oe_o <= fail_r && failresp_r == FAIL_FUSE;
      charge_fet_o <= chg_nxt;
      discharge_fet_o <= dsg_nxt;
      permanent_fail_o <= fail_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration writes, calibration results and link answers
  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      mode_r <= 1'b0;
      vcofs_r <= 16'h0000;
      vdofs_r <= 16'h0000;
      cgain_r <= GAIN_RST;
      dgain_r <= GAIN_RST;
      ccofs_r <= 32'h00000000;
      ccsmp_r <= SMP_RST;
      ccgain_r <= CURRENT_GAIN_RST;
      cap_r <= CAP_SCALE_F;
      ovovr_r <= 8'h00;
      uvovr_r <= 8'h00;
      pen_r <= {NPR{1'b0}};
      pauto_r <= PROT_ALL;
      recov_r <= REC_AUTO;
      failresp_r <= FAIL_FLAG;
      hostfet_r <= HOST_FET_RST;
      for (int i = 0; i < NTS; i++)
        tofs_r[i] <= 16'h0000;
      for (int i = 0; i < NTH; i++)
        thr_r[i] <= 32'h00000000;
      cal_uv_r <= 1'b0;
      cal_busy_r <= 1'b0;
      rsp_vld_r <= 1'b0;
      rsp_err_r <= 1'b0;
      rsp_dat_r <= 32'h00000000;
    end
    else
    begin
      if (wr_w && wok_c)
      begin
        if (a == A_MODE) mode_r <= d[0];
        else if (a == A_VCOFS) vcofs_r <= d[15:0];
        else if (a == A_VDOFS) vdofs_r <= d[15:0];
        else if (a == A_CGAIN) cgain_r <= d[15:0];
        else if (a == A_DGAIN) dgain_r <= d[15:0];
        else if (a == A_CCOFS) ccofs_r <= d;
        else if (a == A_CCSMP) ccsmp_r <= d[15:0];
        else if (a == A_CCGAIN)
        begin
          ccgain_r <= d;
          cap_r <= fmul_ff(d, CAP_SCALE_F);
        end
        else if (a == A_OVOVR) ovovr_r <= d[COEF_W-1:0];
        else if (a == A_UVOVR) uvovr_r <= d[COEF_W-1:0];
        else if (a == A_PEN) pen_r <= d[NPR-1:0];
        else if (a == A_PAUTO) pauto_r <= d[NPR-1:0];
        else if (a == A_RECOV) recov_r <= d[1:0];
        else if (a == A_FAILRESP) failresp_r <= d[1:0];
        else if (a == A_FETCTL) hostfet_r <= d[1:0];
        else if (tofs_hit) tofs_r[tofs_ix] <= d[15:0];
        else if (thr_hit) thr_r[thr_ix] <= d;
      end
      if (cal_ok_w)
      begin
        cal_uv_r <= d == SUB_CAL_UV;
        cal_busy_r <= 1'b1;
      end
      else if (cal_done_w)
      begin
        cal_busy_r <= 1'b0;
        if (cal_uv_r)
          uvovr_r <= coef_w;
        else
          ovovr_r <= coef_w;
      end
      rsp_vld_r <= (link.req_vld && !cal_ok_w) || cal_done_w;
      rsp_err_r <= link.req_vld && !cal_ok_w && !(wr_w && wok_c) &&
        !(rd_w && rok_c);
      if (cal_done_w)
        rsp_dat_r <= {{(DW-COEF_W){1'b0}}, coef_w};
      else if (rd_w && rok_c)
        rsp_dat_r <= rdat_c;
      else
        rsp_dat_r <= 32'h00000000;
    end
  end
endmodule // bmc_device

/* core/bmc_pkg.sv */
// constants, types and helpers shared by both ends of the monitor link
// Contract
// - cells in mV, dividers in user volts
// - threshold calibration only in config-update mode
// - host applies level, then calibration subcommand
// - overvoltage search returns and stores coefficient
// - nonzero overvoltage override replaces factory trim
// - undervoltage search returns and stores coefficient
// - current is raw minus offset, times gain
// - offset in counts over offset samples
// - float gains; capacity gain is scaled current gain
// - host sets gain from sense resistor
// - add 0.1 K offset to each temperature
// - one offset per sensor, ten sensors
// - per-protection enable and autonomous FET select
// - comparator protections versus periodic firmware ones
// - autonomous, host recovery, or alert only
// - permanent fail: flag, FETs off, or fuse
// - fuse pin also sensed as input
// - three discharge overcurrent tiers plus short circuit
// - FET gates follow host and protection state
// - voltage: minus trim, gain over 65536, minus offset
package bmc_pkg;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int NTS = 10;
  localparam int NPR = 11;
  localparam int NTH = 7;
  localparam int COEF_W = 8;
  localparam int GAIN_SHIFT = 16;
  localparam int FP_BIAS = 127;
  localparam int FP_MANT = 23;
  // 298261.6178 rounded to single precision
  localparam logic [31:0] CAP_SCALE_F = 32'h4891A2B4;
  localparam logic [31:0] CURRENT_GAIN_RST = 32'h3F800000;
  localparam logic [15:0] GAIN_RST = 16'h2F58;
  localparam logic [15:0] SMP_RST = 16'h0001;
  localparam logic [1:0] HOST_FET_RST = 2'h3;
  localparam logic [NPR-1:0] PROT_ALL = 11'h7FF;
  localparam int CAL_BASE_MV = 1000;
  localparam int CAL_STEP_MV = 20;
  // protection bit positions
  localparam int P_UV = 0;
  localparam int P_OV = 1;
  localparam int P_OCC = 2;
  localparam int P_OCD1 = 3;
  localparam int P_OCD2 = 4;
  localparam int P_OCD3 = 5;
  localparam int P_SCD = 6;
  localparam int P_OT = 7;
  localparam int P_UT = 8;
  localparam int P_WDG = 9;
  localparam int P_PCH = 10;
  localparam logic [NPR-1:0] FW_MASK = 11'h7A0;
  localparam logic [NPR-1:0] CHARGE_MASK = 11'h586;
  localparam logic [NPR-1:0] DISCH_MASK = 11'h2F9;
  // threshold slots
  localparam int T_OCC = 0;
  localparam int T_OCD1 = 1;
  localparam int T_OCD2 = 2;
  localparam int T_OCD3 = 3;
  localparam int T_SCD = 4;
  localparam int T_OT = 5;
  localparam int T_UT = 6;
  // device link addresses
  localparam logic [AW-1:0] A_MODE = 8'h00;
  localparam logic [AW-1:0] A_VCOFS = 8'h01;
  localparam logic [AW-1:0] A_VDOFS = 8'h02;
  localparam logic [AW-1:0] A_CGAIN = 8'h03;
  localparam logic [AW-1:0] A_DGAIN = 8'h04;
  localparam logic [AW-1:0] A_CCOFS = 8'h05;
  localparam logic [AW-1:0] A_CCSMP = 8'h06;
  localparam logic [AW-1:0] A_CCGAIN = 8'h07;
  localparam logic [AW-1:0] A_CAPGAIN = 8'h08;
  localparam logic [AW-1:0] A_OVOVR = 8'h09;
  localparam logic [AW-1:0] A_UVOVR = 8'h0A;
  localparam logic [AW-1:0] A_PEN = 8'h0B;
  localparam logic [AW-1:0] A_PAUTO = 8'h0C;
  localparam logic [AW-1:0] A_RECOV = 8'h0D;
  localparam logic [AW-1:0] A_FAILRESP = 8'h0E;
  localparam logic [AW-1:0] A_FETCTL = 8'h0F;
  localparam logic [AW-1:0] A_TOFS = 8'h10;
  localparam logic [AW-1:0] A_THR = 8'h20;
  localparam logic [AW-1:0] A_CELLV = 8'h30;
  localparam logic [AW-1:0] A_DIVV = 8'h31;
  localparam logic [AW-1:0] A_CUR = 8'h32;
  localparam logic [AW-1:0] A_FAULT = 8'h33;
  localparam logic [AW-1:0] A_STAT = 8'h34;
  localparam logic [AW-1:0] A_TEMP = 8'h40;
  localparam logic [DW-1:0] SUB_CAL_OV = 32'h00000001;
  localparam logic [DW-1:0] SUB_CAL_UV = 32'h00000002;
  localparam logic [1:0] REC_AUTO = 2'h0;
  localparam logic [1:0] REC_HOST = 2'h1;
  localparam logic [1:0] REC_ALERT = 2'h2;
  localparam logic [1:0] FAIL_FLAG = 2'h0;
  localparam logic [1:0] FAIL_FUSE = 2'h2;
  // host controller register offsets
  localparam logic [2:0] H_ADDR = 3'h0;
  localparam logic [2:0] H_DATA = 3'h1;
  localparam logic [2:0] H_GO = 3'h2;
  localparam logic [2:0] H_STAT = 3'h3;
  localparam logic [2:0] H_RESP = 3'h4;
  localparam logic [2:0] H_PINS = 3'h5;

  typedef enum logic [1:0] {KIND_WR, KIND_RD, KIND_SUB, KIND_NONE} bmc_kind_t;

  function automatic logic signed [31:0] coef_mv(input logic [COEF_W-1:0] c);
    return 32'(CAL_BASE_MV + CAL_STEP_MV * int'(c));
  endfunction

  function automatic logic signed [31:0] cal_volt(input logic [15:0] raw,
    input logic [15:0] trim, input logic [15:0] gain,
    input logic signed [15:0] ofs);
    logic signed [17:0] d;
    logic signed [35:0] p;
    d = $signed({2'h0, raw}) - $signed({2'h0, trim});
    p = d * $signed({2'h0, gain});
    return 32'(p >>> GAIN_SHIFT) - 32'(ofs);
  endfunction

  // integer times float; mantissa is truncated, subnormals read as zero
  function automatic logic signed [31:0] fmul_if(input logic signed [31:0] v,
    input logic [31:0] f);
    logic signed [56:0] p;
    logic signed [31:0] r;
    int sh;
    p = v * $signed({1'b0, 1'b1, f[22:0]});
    sh = FP_BIAS + FP_MANT - int'(f[30:23]);
    if (f[30:23] == 8'h00)
      r = 32'h00000000;
    else if (sh >= 0)
      r = 32'(p >>> sh);
    else
      r = 32'(p <<< (-sh));
    return f[31] ? -r : r;
  endfunction

  function automatic logic [31:0] fmul_ff(input logic [31:0] a,
    input logic [31:0] b);
    logic [47:0] p;
    logic [8:0] e;
    p = {1'b1, a[22:0]} * {1'b1, b[22:0]};
    e = 9'(a[30:23]) + 9'(b[30:23]) - 9'(FP_BIAS);
    if (a[30:23] == 8'h00 || b[30:23] == 8'h00)
      return 32'h00000000;
    if (p[47])
      return {a[31] ^ b[31], e[7:0] + 8'h01, p[46:24]};
    return {a[31] ^ b[31], e[7:0], p[45:23]};
  endfunction
endpackage

/* core/bmc_link_if.sv */
// link between the monitor device and its host controller
`timescale 1ns/1ps
interface bmc_link_if
  import bmc_pkg::*;
();
  logic req_vld;
  bmc_kind_t req_kind;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_data;
  logic rsp_vld;
  logic rsp_err;
  logic [DW-1:0] rsp_data;
  logic charge_fet_block_pin;
  logic discharge_fet_block_pin;
  logic alert;

  modport dev (input req_vld, req_kind, req_addr, req_data,
    charge_fet_block_pin, discharge_fet_block_pin,
    output rsp_vld, rsp_err, rsp_data, alert);
  modport host (output req_vld, req_kind, req_addr, req_data,
    charge_fet_block_pin, discharge_fet_block_pin,
    input rsp_vld, rsp_err, rsp_data, alert);
endinterface

/* core/bmc_cal_search.sv */
// successive-approximation search for a threshold coefficient
`timescale 1ns/1ps
module bmc_cal_search
  import bmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic start_i,
  input wire logic signed [31:0] level_mv_i,
  output logic [COEF_W-1:0] coef_o,
  output logic done_o
);
  logic [COEF_W-1:0] trial_r;
  logic [COEF_W-1:0] bit_r;
  logic busy_r;
  logic [COEF_W-1:0] try_w;
  logic keep_w;

  // largest coefficient whose threshold does not pass the applied level
  assign try_w = trial_r | bit_r;
  assign keep_w = coef_mv(try_w) <= level_mv_i;
  assign coef_o = trial_r;

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      trial_r <= 8'h00;
      bit_r <= 8'h00;
      busy_r <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= busy_r && bit_r[0];
      if (start_i)
      begin
        trial_r <= 8'h00;
        bit_r <= {1'b1, {(COEF_W-1){1'b0}}};
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        if (keep_w)
          trial_r <= try_w;
        bit_r <= bit_r >> 1;
        busy_r <= !bit_r[0];
      end
    end
  end
endmodule // bmc_cal_search

/* core/bmc_host.sv */
// host end: register-driven controller that issues link requests
`timescale 1ns/1ps
module bmc_host
  import bmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  bmc_link_if.host link,
  input wire logic [2:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o
);
  logic [AW-1:0] laddr_r;
  logic [DW-1:0] ldata_r;
  logic [DW-1:0] resp_r;
  bmc_kind_t kind_r;
  logic req_r;
  logic busy_r;
  logic done_r;
  logic err_r;
  logic [1:0] pins_r;
  logic [1:0] alert_s_r;
  logic [31:0] rd_c;

  // one request outstanding; a go while busy is dropped
  wire logic go_w = wr_i && addr_i == H_GO && !busy_r;

  assign link.req_vld = req_r;
  assign link.req_kind = kind_r;
  assign link.req_addr = laddr_r;
  assign link.req_data = ldata_r; // gain words pass untouched
  assign link.charge_fet_block_pin = pins_r[0];
  assign link.discharge_fet_block_pin = pins_r[1];

  always_comb
  begin
    rd_c = 32'h00000000;
    if (addr_i == H_ADDR) rd_c = 32'(laddr_r);
    else if (addr_i == H_DATA) rd_c = ldata_r;
    else if (addr_i == H_STAT)
      rd_c = {28'h0000000, alert_s_r[1], err_r, done_r, busy_r};
    else if (addr_i == H_RESP) rd_c = resp_r;
    else if (addr_i == H_PINS) rd_c = 32'(pins_r);
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      laddr_r <= 8'h00;
      ldata_r <= 32'h00000000;
      resp_r <= 32'h00000000;
      kind_r <= KIND_NONE;
      req_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      pins_r <= 2'h0;
      alert_s_r <= 2'h0;
      rdata_o <= 32'h00000000;
    end
    else
    begin
      alert_s_r <= {alert_s_r[0], link.alert};
      rdata_o <= rd_i ? rd_c : 32'h00000000;
      if (wr_i && addr_i == H_ADDR) laddr_r <= wdata_i[AW-1:0];
      else if (wr_i && addr_i == H_DATA) ldata_r <= wdata_i;
      else if (wr_i && addr_i == H_PINS) pins_r <= wdata_i[1:0];
      req_r <= go_w;
      if (go_w)
      begin
        // the request kind comes from the low two bits of the go word
        kind_r <= bmc_kind_t'(wdata_i[1:0]);
        busy_r <= 1'b1;
        done_r <= 1'b0;
      end
      else if (link.rsp_vld && busy_r)
      begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        err_r <= link.rsp_err;
        resp_r <= link.rsp_data;
      end
    end
  end
endmodule // bmc_host

/* tb/bmc_link_props.sv */
// assertions on the link between the host and device ends
`timescale 1ns/1ps
module bmc_link_props
  import bmc_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic req_vld,
  input wire bmc_kind_t req_kind,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data,
  input wire logic rsp_vld,
  input wire logic rsp_err,
  input wire logic [DW-1:0] rsp_data
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire sub = req_vld && req_kind == KIND_SUB;
  wire bad = !(req_data inside {SUB_CAL_OV, SUB_CAL_UV});
  wire wro = req_vld && req_kind == KIND_WR && req_addr == A_CAPGAIN;
  chk_rsp_pulse: assert property (rsp_vld |=> !rsp_vld)
    else $error("long rsp");
  chk_quick_ans: assert property (req_vld && !sub |=> rsp_vld)
    else $error("late rsp");
  chk_sub_ans: assert property (sub |=> rsp_vld or ##9 rsp_vld)
    else $error("sub rsp");
  chk_sub_code: assert property (sub && bad |=> rsp_err)
    else $error("bad code taken");
  chk_sub_ok: assert property (
    sub ##1 !rsp_vld |-> ##9 rsp_vld && !rsp_err) else $error("cal");
  chk_idle_data: assert property (!rsp_vld |-> rsp_data == '0)
    else $error("idle data");
  chk_ro_write: assert property (wro |=> rsp_vld && rsp_err)
    else $error("ro write");
  chk_no_stray: assert property (
    rsp_vld |-> $past(req_vld) || $past(sub, 10)) else $error("stray");
endmodule // bmc_link_props

/* tb/test_battery_monitor_calibration_protect.sv */
// bench driving both monitor ends through the host register port
`timescale 1ns/1ps
module test_battery_monitor_calibration_protect
  import bmc_pkg::*;
();
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic fail_trigger_i = 1'b0;
  logic e;
  logic [2:0] addr_i = 3'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] v;
  logic [15:0] top_raw_i = 16'h0;
  logic [15:0] cell_raw_i = 16'h0;
  logic signed [31:0] cc_raw_i = 32'h0;
  logic [NTS-1:0][15:0] temp_raw_i = '0;
  logic fuse_o, fuse_oe_o, charge_fet_o, discharge_fet_o, permanent_fail_o;
  logic [15:0] div_raw_i = 16'h0;
  logic fuse_i = 1'b0;
  int mismatches = 0;
  int tests_run = 0;
  int k;
  bmc_link_if link ();
  bmc_device #(.EVAL_CYC(8), .WDOG_CYC(20), .PCHG_CYC(20)) bmc_device_inst (
    .ref_clk_i, .sys_rst_i, .link(link.dev), .cell_raw_i, .top_raw_i,
    .div_raw_i, .cc_raw_i, .temp_raw_i, .pchg_active_i(1'b0),
    .fail_trigger_i, .fuse_i, .fuse_o, .fuse_oe_o, .charge_fet_o,
    .discharge_fet_o, .permanent_fail_o);
  bmc_host bmc_host_inst (.ref_clk_i, .sys_rst_i, .link(link.host),
    .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  bmc_link_props bmc_link_props_inst (.ref_clk_i, .sys_rst_i,
    .req_vld(link.req_vld), .req_kind(link.req_kind),
    .req_addr(link.req_addr), .req_data(link.req_data),
    .rsp_vld(link.rsp_vld), .rsp_err(link.rsp_err), .rsp_data(link.rsp_data));
  // search result: largest code whose threshold stays under the level
  function automatic logic [31:0] cf(input int raw);
    return 32'((raw * int'(GAIN_RST) / 65536 - CAL_BASE_MV) / CAL_STEP_MV);
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, x, input string n);
    tests_run++;
    if (s !== x)
    begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", n, x, s);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= w;
    rd_i <= !w;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 v = rdata_o;
    @(posedge ref_clk_i);
  endtask
  // one link request; busy is polled so no fixed wait is assumed
  task automatic lk(input logic [31:0] n, input logic [7:0] a,
    input logic [31:0] d);
    bus(1'b1, H_ADDR, 32'(a));
    bus(1'b1, H_DATA, d);
    bus(1'b1, H_GO, n);
    // a write returns zero read data, so poll status at least once
    v = 32'h1;
    for (k = 0; k < 30 && v[0] !== 1'b0; k++)
      bus(1'b0, H_STAT, 32'h0);
    e = v[2];
    if (k == 30)
    begin
      mismatches++;
      end_sim;
    end
    bus(1'b0, H_RESP, 32'h0);
  endtask
  initial
  begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    repeat (12) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    v = 32'h1;
    lk(1, A_CAPGAIN, 0);
    chk(v, CAP_SCALE_F, "cap");
    lk(0, A_CAPGAIN, 1);
    chk(e, 1, "ro");
    lk(2, A_MODE, SUB_CAL_OV);
    chk(e, 1, "mode");
    lk(1, A_OVOVR, 0);
    chk(v, 0, "ovr");
    $display("refusal test end");
    top_raw_i <= 16'h4C0A;
    lk(0, A_MODE, 1);
    // in config mode only the unknown code can cause the refusal
    lk(2, A_MODE, 3);
    chk(e, 1, "code");
    lk(2, A_MODE, SUB_CAL_OV);
    chk(v, cf(19466), "ovc");
    lk(1, A_OVOVR, 0);
    chk(v, cf(19466), "ovs");
    top_raw_i <= 16'h3000;
    lk(2, A_MODE, SUB_CAL_UV);
    chk(v, cf(12288), "uvc");
    lk(0, A_MODE, 0);
    lk(0, A_PEN, 2);
    // trips only if the override, not the higher factory trim, is used
    cell_raw_i <= 16'h4C0A;
    repeat (4) @(posedge ref_clk_i);
    #1 chk({charge_fet_o, discharge_fet_o}, 2'h1, "ov");
    bus(1'b0, H_STAT, 32'h0);
    chk(v[3], 1, "alert");
    cell_raw_i <= 16'h0000;
    repeat (4) @(posedge ref_clk_i);
    #1 chk(charge_fet_o, 1, "rec");
    $display("calibration test end");
    cc_raw_i <= 32'h3E8;
    // gain of 2.0 stands for a 3.7384 milliohm sense resistor
    lk(0, A_CCGAIN, 32'h40000000);
    lk(1, A_CAPGAIN, 0);
    chk(v, 32'h4911A2B4, "capg");
    lk(0, A_CCOFS, 32'hC8);
    lk(0, A_CCSMP, 32'h2);
    lk(1, A_CUR, 0);
    chk(v, 2 * (1000 - 200 / 2), "cur");
    temp_raw_i[9] <= 16'h0BA5;
    lk(0, A_TOFS + 8'h09, 32'hFFFFFFFB);
    lk(1, A_TEMP + 8'h09, 0);
    chk(v, 2981 - 5, "tmp");
    div_raw_i <= 16'h3000;
    lk(1, A_DIVV, 0);
    chk(v, 12288 * int'(GAIN_RST) / 65536, "div");
    lk(0, A_FAILRESP, 2);
    fail_trigger_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    #1 chk({permanent_fail_o, fuse_oe_o, charge_fet_o}, 3'h6, "pf");
    chk(fuse_o, 1, "fuse_o");
    // the pin reads high while driven, which must not count as external
    fuse_i <= 1'b1;
    lk(1, A_STAT, 0);
    chk(v, 32'h08, "fuse");
    $display("measure test end");
    end_sim;
  end
endmodule // test_battery_monitor_calibration_protect
